// ==== byte_lane_dll_defines.svh ====
`ifndef BYTE_LANE_DLL_DEFINES_SVH
`define BYTE_LANE_DLL_DEFINES_SVH

// register byte offsets
`define OFS_DLL_CONTROL      12'h28C
`define OFS_DQ_BIT_DELAY     12'h290
`define OFS_STROBE_TIMING    12'h294

// dll control fields
`define DLLC_DISABLE_BIT     31
`define DLLC_SRST_BIT        30
`define DLLC_LOOPBACK_BIT    19
`define DLLC_ATEST_BIT       18
`define DLLC_PHASE_HI        17
`define DLLC_PHASE_LO        14
`define DLLC_START_HI        13
`define DLLC_START_LO        12
`define DLLC_MFF_HI          11
`define DLLC_MFF_LO          9
`define DLLC_MFB_HI          8
`define DLLC_MFB_LO          6
`define DLLC_SFF_HI          5
`define DLLC_SFF_LO          3
`define DLLC_SFB_HI          2
`define DLLC_SFB_LO          0
`define DLLC_WRITE_MASK      32'hC00FFFFF
`define DLLC_RESET           32'h40000000

// dq bit delay
`define DQ_FIELD_W           4
`define DQ_BITS              8
`define DQ_RESET             32'hFFFFFFFF

// strobe timing
`define STRB_WRITE_MASK      32'h3FFFFFFF
`define STRB_RESET           32'h3DB55000
`define STRB_MASK_HI         29
`define STRB_MASK_LO         26

// slave phase arithmetic, in degrees
`define PHASE_BASE_DEG       8'h5A
`define PHASE_STEP_DEG       8'h12

// avalon response codes
`define RESP_OKAY            2'h0
`define RESP_SLVERR          2'h2

`endif

// ==== byte_lane_dll_pkg.sv ====
package byte_lane_dll_pkg;

	typedef enum logic {
		BUS_IDLE,
		BUS_ANSWER
	} bus_state_t;

	typedef struct packed {
		bus_state_t  bus_state;
		logic        waitrequest;
		logic [31:0] readdata;
		logic [1:0]  response;
		logic [31:0] dll_ctrl;
		logic [31:0] dq_delay;
		logic [31:0] strobe;
		logic [7:0]  phase_deg;
		logic        auto_start;
		logic        phase_detect_en;
		logic [7:0]  dq_true_delay_lo;
		logic [7:0]  dq_true_delay_hi;
		logic [7:0]  dq_comp_delay_lo;
		logic [7:0]  dq_comp_delay_hi;
	} lane_state_t;

endpackage

// ==== ddr_phy_byte_lane_dll_delay_regs.sv ====
`timescale 1ns/1ps
`include "byte_lane_dll_defines.svh"

// What this block does
// - dll control bit 30 drives dll soft reset
// - bit 19 puts slave dll in loopback
// - bit 18 enables analog test, else tristated
// - phase trim gives 90+18hi-18lo degrees
// - startup field chooses auto start, phase detector
// - master trims at 11:9, 8:6, reset zero
// - slave trims at 5:3, 2:0, reset zero
// - eight four-bit dq delays, reset 0xF each
// - low pair true strobe, high pair complement
// - strobe timing bits 31:30 read zero
// - bit 31 disables dll into bypass
module ddr_phy_byte_lane_dll_delay_regs
	import byte_lane_dll_pkg::*;
(
	// clock, reset, enable
	input  wire logic        clock_i,
	input  wire logic        arst_n_i,
	input  wire logic        ce_i,
	// avalon-mm slave
	input  wire logic [11:0] address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic      [1:0]  response_o,
	output logic             waitrequest_o,
	// byte dll controls
	output logic             lane_dll_disable_o,
	output logic             lane_dll_soft_reset_o,
	output logic             slave_loopback_mode_o,
	output logic             analog_test_out_enable_o,
	output logic      [3:0]  slave_phase_trim_o,
	output logic      [7:0]  slave_phase_deg_o,
	output logic      [1:0]  slave_startup_policy_o,
	output logic             slave_auto_start_o,
	output logic             slave_phase_detect_en_o,
	output logic      [2:0]  master_ff_delay_trim_o,
	output logic      [2:0]  master_fb_delay_trim_o,
	output logic      [2:0]  slave_ff_delay_trim_o,
	output logic      [2:0]  slave_fb_delay_trim_o,
	// per-bit data delays
	output logic      [31:0] data_delay_o,
	output logic      [15:0] dq_true_delay_o,
	output logic      [15:0] dq_comp_delay_o,
	// strobe timing
	output logic      [3:0]  mask_delay_o,
	output logic      [29:0] strobe_timing_o
);

	lane_state_t r;
	lane_state_t nxt;

	logic [31:0] be_mask;
	logic [31:0] dq_nxt;
	logic [15:0] true_nxt;
	logic [15:0] comp_nxt;

	// byte enables widened to a bit mask
	always_comb begin
		be_mask = {{8{byteenable_i[3]}},
		           {8{byteenable_i[2]}},
		           {8{byteenable_i[1]}},
		           {8{byteenable_i[0]}}};
	end

	// merge a write under byte enables and the writable mask
	function automatic logic [31:0] merge(input logic [31:0] old_v,
	                                      input logic [31:0] new_v,
	                                      input logic [31:0] be,
	                                      input logic [31:0] wmask);
		logic [31:0] m;
		m = be & wmask;
		merge = (old_v & ~m) | (new_v & m);
	endfunction

	// next dq delay value, kept out of the state process so the split sees no loop
	always_comb begin
		dq_nxt = r.dq_delay;
		if (r.bus_state == BUS_ANSWER && write_i && address_i == `OFS_DQ_BIT_DELAY) begin
			dq_nxt = merge(r.dq_delay, writedata_i, be_mask, 32'hFFFFFFFF);
		end
	end

	// split each dq field into its two strobe pairs
	genvar g;
	generate
		for (g = 0; g < `DQ_BITS; g = g + 1) begin : g_dq
			assign true_nxt[2*g +: 2] = dq_nxt[4*g +: 2];
			assign comp_nxt[2*g +: 2] = dq_nxt[4*g + 2 +: 2];
		end
	endgenerate

	// next-state logic
	always_comb begin
		logic [1:0] ph_hi;
		logic [1:0] ph_lo;
		logic [1:0] start;
		ph_hi = 2'h0;
		ph_lo = 2'h0;
		start = 2'h0;
		nxt = r;

		// bus handshake: answer one cycle after the request appears
		case (r.bus_state)
			BUS_IDLE: begin
				nxt.waitrequest = 1'b1;
				if (read_i || write_i) begin
					nxt.bus_state = BUS_ANSWER;
					nxt.waitrequest = 1'b0;
					nxt.response = `RESP_OKAY;
					nxt.readdata = 32'h00000000;
					if (address_i == `OFS_DLL_CONTROL) begin
						nxt.readdata = r.dll_ctrl & `DLLC_WRITE_MASK;
					end else if (address_i == `OFS_DQ_BIT_DELAY) begin
						nxt.readdata = r.dq_delay;
					end else if (address_i == `OFS_STROBE_TIMING) begin
						nxt.readdata = r.strobe & `STRB_WRITE_MASK;
					end else begin
						nxt.response = `RESP_SLVERR;
					end
					if (!read_i) begin
						nxt.readdata = 32'h00000000;
					end
				end
			end
			BUS_ANSWER: begin
				// the write takes effect at the edge that sees waitrequest low
				nxt.bus_state = BUS_IDLE;
				nxt.waitrequest = 1'b1;
				if (write_i) begin
					if (address_i == `OFS_DLL_CONTROL) begin
						nxt.dll_ctrl = merge(r.dll_ctrl, writedata_i, be_mask,
						                     `DLLC_WRITE_MASK);
					end else if (address_i == `OFS_DQ_BIT_DELAY) begin
						nxt.dq_delay = dq_nxt;
					end else if (address_i == `OFS_STROBE_TIMING) begin
						nxt.strobe = merge(r.strobe, writedata_i, be_mask,
						                   `STRB_WRITE_MASK);
					end
				end
			end
			default: begin
				nxt.bus_state = BUS_IDLE;
				nxt.waitrequest = 1'b1;
			end
		endcase

		// slave phase in degrees from the trim field
		ph_hi = nxt.dll_ctrl[`DLLC_PHASE_HI:`DLLC_PHASE_HI - 1];
		ph_lo = nxt.dll_ctrl[`DLLC_PHASE_LO + 1:`DLLC_PHASE_LO];
		nxt.phase_deg = `PHASE_BASE_DEG
		              + ({6'h00, ph_hi} * `PHASE_STEP_DEG)
		              - ({6'h00, ph_lo} * `PHASE_STEP_DEG);

		// startup policy decode
		start = nxt.dll_ctrl[`DLLC_START_HI:`DLLC_START_LO];
		nxt.auto_start = ~start[1];
		nxt.phase_detect_en = ~start[1] | start[0];

		// per-strobe data delays, two bits per data bit
		nxt.dq_true_delay_lo = true_nxt[15:8];
		nxt.dq_true_delay_hi = true_nxt[7:0];
		nxt.dq_comp_delay_lo = comp_nxt[15:8];
		nxt.dq_comp_delay_hi = comp_nxt[7:0];
	end

	// state register, frozen while the clock enable is low
	always_ff @(posedge clock_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			r.bus_state        <= BUS_IDLE;
			r.waitrequest      <= 1'b1;
			r.readdata         <= 32'h00000000;
			r.response         <= `RESP_OKAY;
			r.dll_ctrl         <= `DLLC_RESET;
			r.dq_delay         <= `DQ_RESET;
			r.strobe           <= `STRB_RESET;
			r.phase_deg        <= `PHASE_BASE_DEG;
			r.auto_start       <= 1'b1;
			r.phase_detect_en  <= 1'b1;
			r.dq_true_delay_lo <= 8'hFF;
			r.dq_true_delay_hi <= 8'hFF;
			r.dq_comp_delay_lo <= 8'hFF;
			r.dq_comp_delay_hi <= 8'hFF;
		end else if (ce_i) begin
			r <= nxt;
		end
	end

	// bus outputs
	assign readdata_o    = r.readdata;
	assign response_o    = r.response;
	assign waitrequest_o = r.waitrequest;

	// dll controls from the control register, phase degrees and startup decodes from their own registers
	assign lane_dll_disable_o       = r.dll_ctrl[`DLLC_DISABLE_BIT];
	assign lane_dll_soft_reset_o    = r.dll_ctrl[`DLLC_SRST_BIT];
	assign slave_loopback_mode_o    = r.dll_ctrl[`DLLC_LOOPBACK_BIT];
	assign analog_test_out_enable_o = r.dll_ctrl[`DLLC_ATEST_BIT];
	assign slave_phase_trim_o       = r.dll_ctrl[`DLLC_PHASE_HI:`DLLC_PHASE_LO];
	assign slave_phase_deg_o        = r.phase_deg;
	assign slave_startup_policy_o   = r.dll_ctrl[`DLLC_START_HI:`DLLC_START_LO];
	assign slave_auto_start_o       = r.auto_start;
	assign slave_phase_detect_en_o  = r.phase_detect_en;
	assign master_ff_delay_trim_o   = r.dll_ctrl[`DLLC_MFF_HI:`DLLC_MFF_LO];
	assign master_fb_delay_trim_o   = r.dll_ctrl[`DLLC_MFB_HI:`DLLC_MFB_LO];
	assign slave_ff_delay_trim_o    = r.dll_ctrl[`DLLC_SFF_HI:`DLLC_SFF_LO];
	assign slave_fb_delay_trim_o    = r.dll_ctrl[`DLLC_SFB_HI:`DLLC_SFB_LO];

	// data and strobe delays
	assign data_delay_o    = r.dq_delay;
	assign dq_true_delay_o = {r.dq_true_delay_lo, r.dq_true_delay_hi};
	assign dq_comp_delay_o = {r.dq_comp_delay_lo, r.dq_comp_delay_hi};
	assign mask_delay_o    = r.strobe[`STRB_MASK_HI:`STRB_MASK_LO];
	assign strobe_timing_o = r.strobe[29:0];

endmodule

// ==== ddr_phy_byte_lane_dll_delay_regs_assertions.sv ====
`timescale 1ns/1ps
module ddr_phy_byte_lane_dll_delay_regs_assertions (
	input logic        clock_i,
	input logic        arst_n_i,
	input logic        ce_i,
	input logic [11:0] address_i,
	input logic        read_i,
	input logic        write_i,
	input logic [31:0] writedata_i,
	input logic [3:0]  byteenable_i,
	input logic [31:0] readdata_o,
	input logic [1:0]  response_o,
	input logic        waitrequest_o,
	input logic        lane_dll_soft_reset_o,
	input logic        slave_loopback_mode_o,
	input logic        analog_test_out_enable_o,
	input logic [3:0]  slave_phase_trim_o,
	input logic [7:0]  slave_phase_deg_o,
	input logic [1:0]  slave_startup_policy_o,
	input logic        slave_auto_start_o,
	input logic        slave_phase_detect_en_o
);
	default clocking @(posedge clock_i); endclocking
	default disable iff (!arst_n_i);
	logic acc_ok;
	logic wr_ctl;
	logic mapped;
	assign acc_ok = (read_i | write_i) & !waitrequest_o;
	assign wr_ctl = acc_ok & write_i & (address_i == 12'h28C);
	assign mapped = address_i inside {12'h28C, 12'h290, 12'h294};
	chk_wait_answer: assert property ((read_i | write_i) && waitrequest_o && ce_i |=> !waitrequest_o)
		else $error("no answer one cycle after request");
	chk_wait_single: assert property (!waitrequest_o && ce_i |=> waitrequest_o)
		else $error("answer held longer than one cycle");
	chk_srst_follow: assert property (wr_ctl && byteenable_i[3] |=> lane_dll_soft_reset_o == $past(writedata_i[30]))
		else $error("soft reset output not written");
	chk_loop_follow: assert property (wr_ctl && byteenable_i[2] |=> slave_loopback_mode_o == $past(writedata_i[19]))
		else $error("loopback output not written");
	chk_atest_follow: assert property (wr_ctl && byteenable_i[2] |=> analog_test_out_enable_o == $past(writedata_i[18]))
		else $error("test output enable not written");
	chk_phase_deg: assert property (slave_phase_deg_o == 8'h5A + 8'h12 * slave_phase_trim_o[3:2] - 8'h12 * slave_phase_trim_o[1:0])
		else $error("phase degrees wrong");
	chk_startup_map: assert property (slave_auto_start_o == !slave_startup_policy_o[1] && slave_phase_detect_en_o == (!slave_startup_policy_o[1] | slave_startup_policy_o[0]))
		else $error("startup decode wrong");
	chk_strobe_resv: assert property (acc_ok && read_i && address_i == 12'h294 |-> readdata_o[31:30] == 2'h0)
		else $error("strobe reserved bits not zero");
	chk_ctl_resv: assert property (acc_ok && read_i && address_i == 12'h28C |-> readdata_o[29:20] == 10'h000)
		else $error("control reserved bits not zero");
	chk_unmapped_resp: assert property (acc_ok && read_i && !mapped |-> response_o == 2'h2 && readdata_o == 32'h0)
		else $error("unmapped read answered wrongly");
	chk_ce_freeze: assert property (!ce_i |=> $stable(waitrequest_o) && $stable(readdata_o)
		&& $stable(response_o) && $stable(slave_phase_deg_o) && $stable(slave_loopback_mode_o))
		else $error("state moved while clock enable low");
	cover property (!ce_i && (read_i | write_i));
	cover property (wr_ctl);
	cover property (acc_ok && read_i && !mapped);
	cover property (acc_ok && read_i && address_i == 12'h294);
endmodule

// ==== ddr_phy_byte_lane_dll_delay_regs_bench.sv ====
`timescale 1ns/1ps
`include "byte_lane_dll_defines.svh"
module ddr_phy_byte_lane_dll_delay_regs_bench;
	logic        clock_i = 1'b0, arst_n_i = 1'b0, ce_i = 1'b1, read_i = 1'b0, write_i = 1'b0;
	logic [11:0] address_i = 12'h000;
	logic [31:0] writedata_i = 32'h0, readdata_o, data_delay_o, rd, m [3], wm [3];
	logic [3:0]  byteenable_i = 4'h0, slave_phase_trim_o, mask_delay_o;
	logic [1:0]  response_o, slave_startup_policy_o, rs;
	logic        waitrequest_o, lane_dll_disable_o, lane_dll_soft_reset_o, slave_loopback_mode_o;
	logic        analog_test_out_enable_o, slave_auto_start_o, slave_phase_detect_en_o;
	logic [7:0]  slave_phase_deg_o;
	logic [2:0]  master_ff_delay_trim_o, master_fb_delay_trim_o, slave_ff_delay_trim_o, slave_fb_delay_trim_o;
	logic [15:0] dq_true_delay_o, dq_comp_delay_o;
	logic [29:0] strobe_timing_o;
	int          err_total = 0, samples_checked = 0, cyc = 0;
	ddr_phy_byte_lane_dll_delay_regs DUT (.*);
	always #5 clock_i = ~clock_i;
	always @(posedge clock_i) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			finish_test();
		end
	end
	task finish_test();
		$display("checks=%0d errors=%0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	task check(input logic [31:0] v, input logic [31:0] e);
		samples_checked++;
		if (v !== e) begin
			err_total++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, v, e);
		end
	endtask
	function logic [31:0] split(input logic [31:0] v);
		for (int n = 0; n < 8; n++) begin
			split[2*n +: 2] = v[4*n +: 2];
			split[16+2*n +: 2] = v[4*n+2 +: 2];
		end
	endfunction
	task acc(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] b);
		int i;
		logic [31:0] k;
		i = (a - 12'h28C) / 4;
		k = {{8{b[3]}}, {8{b[2]}}, {8{b[1]}}, {8{b[0]}}};
		@(posedge clock_i);
		read_i <= !w;
		write_i <= w;
		address_i <= a;
		writedata_i <= d;
		byteenable_i <= b;
		do @(posedge clock_i); while (waitrequest_o !== 1'b0);
		rd = readdata_o;
		rs = response_o;
		read_i <= 1'b0;
		write_i <= 1'b0;
		if (a < 12'h28C || i > 2) begin
			check({30'h0, rs}, 32'h2);
			check(rd, 32'h0);
		end else begin
			check({30'h0, rs}, 32'h0);
			if (w) m[i] = (m[i] & ~(k & wm[i])) | (d & k & wm[i]);
			else check(rd, m[i]);
		end
	endtask
	task outs();
		@(negedge clock_i);
		check({lane_dll_disable_o, lane_dll_soft_reset_o, slave_loopback_mode_o, analog_test_out_enable_o},
			{m[0][31:30], m[0][19:18]});
		check(slave_phase_deg_o, 8'h5A + 8'h12 * m[0][17:16] - 8'h12 * m[0][15:14]);
		check({slave_phase_trim_o, slave_startup_policy_o, slave_auto_start_o, slave_phase_detect_en_o},
			{m[0][17:12], !m[0][13], !m[0][13] | m[0][12]});
		check({master_ff_delay_trim_o, master_fb_delay_trim_o, slave_ff_delay_trim_o, slave_fb_delay_trim_o},
			m[0][11:0]);
		check(data_delay_o, m[1]);
		check({dq_comp_delay_o, dq_true_delay_o}, split(m[1]));
		check(strobe_timing_o, m[2][29:0]);
		check(mask_delay_o, m[2][29:26]);
	endtask
	initial begin
		m = '{`DLLC_RESET, `DQ_RESET, `STRB_RESET};
		wm = '{`DLLC_WRITE_MASK, 32'hFFFFFFFF, `STRB_WRITE_MASK};
		void'($urandom(32'h83AF81F4));
		repeat (3) @(posedge clock_i);
		arst_n_i <= 1'b1;
		outs();
		for (int a = 12'h284; a < 12'h29C; a += 4) acc(1'b0, 12'(a), 32'h0, 4'h0);
		acc(1'b1, 12'h28C, 32'hFFFFFFFF, 4'hF);
		acc(1'b1, 12'h294, 32'hFFFFFFFF, 4'hF);
		acc(1'b1, 12'h298, 32'h0, 4'hF);
		outs();
		for (int a = 12'h28C; a < 12'h29C; a += 4) acc(1'b0, 12'(a), 32'h0, 4'h0);
		for (int i = 0; i < 16; i++) begin
			acc(1'b1, 12'h28C, {14'h0, 4'(i), 2'(i), 12'h0}, 4'h6);
			outs();
		end
		@(posedge clock_i);
		ce_i <= 1'b0;
		fork
			acc(1'b1, 12'h28C, 32'h00080000, 4'h4);
			begin
				repeat (4) @(posedge clock_i);
				ce_i <= 1'b1;
			end
		join
		outs();
		repeat (300) begin
			acc(1'($urandom), 12'h28C + 12'(4 * ($urandom % 4)), $urandom, 4'($urandom));
			outs();
		end
		finish_test();
	end
endmodule
bind ddr_phy_byte_lane_dll_delay_regs ddr_phy_byte_lane_dll_delay_regs_assertions chk (.*);
